// ===== inc/dcf_pkg.sv
// Shared constants for the dual clock sixteen bit FIFO
package dcf_pkg;
   // Data path width in bits
   localparam int DCF_DATA_W = 16;
   // Default storage depth in words (256, 512, 1024, 2048 or 4096)
   localparam int DCF_DEPTH_DEF = 256;
   // Output register contents after reset
   localparam logic [15:0] DCF_DATA_RST = 16'h0000;
   // Pointer reset value, the first storage location
   localparam logic [12:0] DCF_PTR_RST = 13'h0000;
   // Flag levels held during reset
   localparam logic DCF_FULL_RST = 1'h0;
   localparam logic DCF_EMPTY_RST = 1'h1;
endpackage : dcf_pkg

// ===== verilog/dcf_ram.sv
// Storage array with one clocked write port and one unclocked read port
`timescale 1ns/1ns
module dcf_ram
   import dcf_pkg::*;
#(
   parameter int W = DCF_DATA_W,
   parameter int AW = 8
) (
   // Write side, on the write clock
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   // Read side, decoded without a clock
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   // The words themselves; no reset, contents are unknown until written
   logic [W-1:0] mem [0:(1<<AW)-1];

   // Store one word per accepted write
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read path feeds the output register in the read domain
   assign rd_data = mem[rd_addr];
endmodule // dcf_ram

// ===== verilog/dcf_gray_sync.sv
// Two flip-flop synchroniser for a gray coded pointer
`timescale 1ns/1ns
module dcf_gray_sync #(
   parameter int W = 9
) (
   // Destination clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Pointer from the other domain, and its settled copy
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // First stage; only the second stage reads it
   logic [W-1:0] meta_r;
   // Second stage, safe for logic to read
   logic [W-1:0] sync_r;

   // Gray code moves one bit per step, so a bus sync is safe here
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;
endmodule // dcf_gray_sync

// ===== verilog/dcf_fifo.sv
// Dual clock FIFO: write port, read port, flags and output drive
//
// Behaviour
// - Accepted write stores word at next location
// - Write enable high stores nothing
// - Writes proceed regardless of concurrent reads
// - First write lifts the empty flag
// - Half-full asserts at word depth/2 + 1
// - Full after depth writes, blocks further writes
// - First read from full clears full
// - Last read sets empty; reads then ignored
// - Reset returns both pointers to start
// - Reset: not full, empty, not half-full
// - Reset clears the output register
// - Accepted read loads next word to output
// - Read enable high holds output register
// - Every word needs its own read request
// - Full flag changes on write clock only
// - Empty flag changes on read clock only
// - Half-full asynchronous, set by write edge
// - Read edge clears half-full at half or below
// - Output enable passed out as read_data_oe_n; read data always driven
// - Full clears two or three write cycles later
// - Empty clears two or three read cycles later
// - Clocks may be unrelated or identical
`timescale 1ns/1ns
module dcf_fifo
   import dcf_pkg::*;
#(
   parameter int DEPTH = DCF_DEPTH_DEF,
   parameter int W = DCF_DATA_W
) (
   // Write domain clock and common reset
   input wire logic write_clock,
   input wire logic nrst,
   // Write port
   input wire logic write_en_n,
   input wire logic [W-1:0] write_data,
   output logic full_flag_n,
   // Read domain clock and read port
   input wire logic read_clock,
   input wire logic read_en_n,
   input wire logic oe_n,
   output logic [W-1:0] read_data,
   output logic read_data_oe_n,
   output logic empty_flag_n,
   // Asynchronous occupancy flag
   output logic half_full_flag_n
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   // Occupancy above this raises half-full
   localparam logic [PW-1:0] HALF = PW'(DEPTH / 2);
   localparam logic [PW-1:0] ONE = PW'(1);

   // Gray to binary, used on both sides and by the flag decode
   function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Binary to gray
   function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // ---------------- Write domain state ----------------
   // Binary write pointer with wrap bit
   logic [PW-1:0] wbin_r, wbin_nxt;
   // Gray copy, the only form that leaves this domain
   logic [PW-1:0] wgray_r, wgray_nxt;
   // Full, active high internally; decoded from two write-domain registers
   logic is_full;
   // Read pointer as seen from the write domain
   logic [PW-1:0] rgray_wsync;
   // Write accepted this edge
   logic wr_ok;

   // ---------------- Read domain state ----------------
   // Binary read pointer with wrap bit
   logic [PW-1:0] rbin_r, rbin_nxt;
   // Gray copy handed to the write domain
   logic [PW-1:0] rgray_r, rgray_nxt;
   // Empty, active high internally; decoded from two read-domain registers
   logic is_empty;
   // Output register
   logic [W-1:0] rdata_r, rdata_nxt;
   // Write pointer as seen from the read domain
   logic [PW-1:0] wgray_rsync;
   // Read accepted this edge
   logic rd_ok;
   // Word presented by the array at the read pointer
   logic [W-1:0] ram_q;

   // Occupancy from the two live gray pointers, for half-full
   logic [PW-1:0] occ_async;

   // gray crossing holds for unrelated or shared clocks
   // read pointer into the write domain
   dcf_gray_sync #(.W(PW)) u_rsync (
      .clock(write_clock),
      .nrst(nrst),
      .din(rgray_r),
      .dout(rgray_wsync)
   );

   // write pointer into the read domain
   dcf_gray_sync #(.W(PW)) u_wsync (
      .clock(read_clock),
      .nrst(nrst),
      .din(wgray_r),
      .dout(wgray_rsync)
   );

   // Storage; written only on accepted writes
   dcf_ram #(.W(W), .AW(AW)) u_ram (
      .clock(write_clock),
      .wr_en(wr_ok),
      .wr_addr(wbin_r[AW-1:0]),
      .wr_data(write_data),
      .rd_addr(rbin_r[AW-1:0]),
      .rd_data(ram_q)
   );

   // Write side next state
   always_comb begin
      // accept only with enable low and room left
      wr_ok = !write_en_n && !is_full;
      wbin_nxt = wbin_r;
      // advance depends on nothing in the read domain but full
      if (wr_ok) begin
         wbin_nxt = wbin_r + ONE;
      end
      wgray_nxt = b2g(wbin_nxt);
   end

   // full when the pointers differ by exactly one lap.
   // both operands move only on the write edge; decoding them
   // without a further register keeps the clear to two or three write edges.
   assign is_full = (wgray_r == {~rgray_wsync[PW-1:PW-2], rgray_wsync[PW-3:0]});

   // Write side registers
   always_ff @(posedge write_clock or negedge nrst) begin
      if (!nrst) begin
         wbin_r <= DCF_PTR_RST[PW-1:0];
         wgray_r <= DCF_PTR_RST[PW-1:0];
      end else begin
         wbin_r <= wbin_nxt;
         wgray_r <= wgray_nxt;
      end
   end

   // Read side next state
   always_comb begin
      rd_ok = !read_en_n && !is_empty;
      rbin_nxt = rbin_r;
      // output register holds unless a read is taken
      rdata_nxt = rdata_r;
      // nothing falls through; only a read loads the register
      if (rd_ok) begin
         rbin_nxt = rbin_r + ONE;
         rdata_nxt = ram_q;
      end
      rgray_nxt = b2g(rbin_nxt);
   end

   // empty clears once the synced write pointer moves.
   // both operands move only on the read edge.
   assign is_empty = (rgray_r == wgray_rsync);

   // Read side registers
   always_ff @(posedge read_clock or negedge nrst) begin
      if (!nrst) begin
         rbin_r <= DCF_PTR_RST[PW-1:0];
         rgray_r <= DCF_PTR_RST[PW-1:0];
         rdata_r <= DCF_DATA_RST[W-1:0];
      end else begin
         rbin_r <= rbin_nxt;
         rgray_r <= rgray_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // half-full decoded straight from both live pointers.
   // Set right after a write edge, cleared right after a read edge;
   // gray steps keep the decode from seeing a false jump mid-change.
   // occupancy of depth/2 + 1 trips it
   assign occ_async = g2b(wgray_r) - g2b(rgray_r);
   assign half_full_flag_n = !(occ_async > HALF);

   // Flags out, active low
   // zeroed pointers decode as empty and not full
   assign full_flag_n = !is_full;
   assign empty_flag_n = !is_empty;

   // enable passed straight out as read_data_oe_n; read_data always carries the register
   assign read_data = rdata_r;
   assign read_data_oe_n = oe_n;

   // ---------------- Checks ----------------
   // Occupancy seen from the write side, never below the true count
   logic [PW-1:0] wocc;
   // Occupancy seen from the read side, never above the true count
   logic [PW-1:0] rocc;
   assign wocc = wbin_r - g2b(rgray_wsync);
   assign rocc = g2b(wgray_rsync) - rbin_r;

   property p_write_adv;
      @(posedge write_clock) disable iff (!nrst)
      (!write_en_n && !is_full) |=> (wbin_r == $past(wbin_r) + ONE);
   endproperty
   a_write_adv: assert property (p_write_adv)
      else $error("accepted write did not advance the write pointer");

   property p_write_idle;
      @(posedge write_clock) disable iff (!nrst)
      write_en_n |=> $stable(wbin_r);
   endproperty
   a_write_idle: assert property (p_write_idle)
      else $error("write pointer moved with write enable high");

   property p_full_blocks;
      @(posedge write_clock) disable iff (!nrst)
      (!full_flag_n && !write_en_n) |=> (wbin_r == $past(wbin_r));
   endproperty
   a_full_blocks: assert property (p_full_blocks)
      else $error("write taken while full");

   property p_full_count;
      @(posedge write_clock) disable iff (!nrst)
      !full_flag_n |-> (wocc == PW'(DEPTH));
   endproperty
   a_full_count: assert property (p_full_count)
      else $error("full flag low without a whole depth stored");

   property p_read_adv;
      @(posedge read_clock) disable iff (!nrst)
      (!read_en_n && empty_flag_n) |=> (rbin_r == $past(rbin_r) + ONE) && (rdata_r == $past(ram_q));
   endproperty
   a_read_adv: assert property (p_read_adv)
      else $error("accepted read did not load the next word");

   property p_read_hold;
      @(posedge read_clock) disable iff (!nrst)
      read_en_n |=> $stable(rdata_r) && $stable(rbin_r);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("output register changed with read enable high");

   property p_empty_blocks;
      @(posedge read_clock) disable iff (!nrst)
      !empty_flag_n |=> $stable(rbin_r) && $stable(read_data);
   endproperty
   a_empty_blocks: assert property (p_empty_blocks)
      else $error("read taken while empty");

   property p_empty_match;
      @(posedge read_clock) disable iff (!nrst)
      empty_flag_n == (rocc != '0);
   endproperty
   a_empty_match: assert property (p_empty_match)
      else $error("empty flag disagrees with the synced occupancy");

   property p_half_bound;
      @(posedge write_clock) disable iff (!nrst)
      !half_full_flag_n |-> (wocc > HALF);
   endproperty
   a_half_bound: assert property (p_half_bound)
      else $error("half-full low with no more than half stored");

   property p_drive;
      @(posedge read_clock) disable iff (!nrst)
      (read_data_oe_n == oe_n) && (read_data == rdata_r);
   endproperty
   a_drive: assert property (p_drive)
      else $error("output drive does not follow output enable");

   property p_reset_flags;
      @(posedge read_clock)
      !nrst |-> (empty_flag_n == !DCF_EMPTY_RST) && (full_flag_n == !DCF_FULL_RST) && half_full_flag_n;
   endproperty
   a_reset_flags: assert property (p_reset_flags)
      else $error("flags not at their reset levels during reset");

   property p_reset_data;
      @(posedge read_clock)
      !nrst |-> (read_data == DCF_DATA_RST[W-1:0]);
   endproperty
   a_reset_data: assert property (p_reset_data)
      else $error("output register not cleared during reset");
endmodule // dcf_fifo

// ===== testbench/dcf_consumer.sv
// Consumer model that drains the read port of the FIFO
`timescale 1ns/1ns
module dcf_consumer
   import dcf_pkg::*;
(
   // Read clock and pacing from the bench
   input wire logic read_clock,
   input wire logic go,
   input wire logic [2:0] rate,
   // Read port of the FIFO
   input wire logic [DCF_DATA_W-1:0] read_data,
   input wire logic empty_flag_n,
   output logic read_en_n
);
   // Words taken, oldest first
   logic [DCF_DATA_W-1:0] q[$];
   // Empty flag as it stood before the coming rising edge
   logic ok;
   initial begin
      read_en_n = 1'h1;
      ok = 1'h0;
   end
   // Decide at the falling edge so the request is settled long before sampling
   always @(negedge read_clock) begin
      if (!read_en_n && ok) begin
         q.push_back(read_data);
      end
      ok = empty_flag_n;
      // Rate 4 or more reads every cycle; rates 1 to 3 stall at random, rate 0 never reads
      read_en_n <= !(go && ($urandom_range(3) < rate));
   end
endmodule // dcf_consumer

// ===== testbench/dcf_fifo_tb_top.sv
// Self-checking bench for the dual clock FIFO
`timescale 1ns/1ns
module dcf_fifo_tb_top
   import dcf_pkg::*;
;
   localparam int DEPTH = 256;
   logic write_clock, read_clock, rclk_free, nrst, write_en_n, oe_n, go;
   // Ties the read clock to the write clock for the shared clock case
   logic tie = 1'h0;
   logic [2:0] rate;
   logic [15:0] write_data, read_data, last;
   logic full_flag_n, read_en_n, read_data_oe_n, empty_flag_n, half_full_flag_n;
   // Words the bench expects to come out, in order
   logic [15:0] exp[$];
   int fails, n_checks, i;

   dcf_fifo #(.DEPTH(DEPTH), .W(16)) dut (.write_clock(write_clock), .nrst(nrst),
      .write_en_n(write_en_n), .write_data(write_data), .full_flag_n(full_flag_n),
      .read_clock(read_clock), .read_en_n(read_en_n), .oe_n(oe_n), .read_data(read_data),
      .read_data_oe_n(read_data_oe_n), .empty_flag_n(empty_flag_n),
      .half_full_flag_n(half_full_flag_n));

   dcf_consumer cons (.read_clock(read_clock), .go(go), .rate(rate), .read_data(read_data),
      .empty_flag_n(empty_flag_n), .read_en_n(read_en_n));

   // Write clock at 100 MHz; read clock unrelated at about 71 MHz
   initial begin
      write_clock = 1'h0;
      forever #5 write_clock = ~write_clock;
   end
   initial begin
      rclk_free = 1'h0;
      #3;
      forever #7 rclk_free = ~rclk_free;
   end
   // Switched only while the write clock is low, so no extra rising edge
   assign read_clock = tie ? write_clock : rclk_free;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, want, seen);
      end
   endtask

   task automatic final_report();
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One write cycle; the full flag seen now is the one the next edge uses
   task automatic put(input logic en, input logic [15:0] d);
      @(negedge write_clock);
      write_en_n = !en;
      write_data = d;
      if (en && full_flag_n) begin
         exp.push_back(d);
      end
   endtask

   // Let the consumer catch up, then compare every word in order
   task automatic drain();
      put(1'h0, 16'h0000);
      for (int k = 0; k < 5000 && cons.q.size() < exp.size(); k++) begin
         @(posedge read_clock);
      end
      chk("word count", cons.q.size(), exp.size());
      foreach (exp[j]) begin
         if (j < cons.q.size()) begin
            chk("word", cons.q[j], exp[j]);
         end
      end
      exp.delete();
      cons.q.delete();
   endtask

   // Reset flags and output register, with output drive on
   task automatic reset_check();
      @(negedge write_clock);
      nrst = 1'h0;
      // no write request stands across reset or its release
      write_en_n = 1'h1;
      repeat (16) @(negedge write_clock);
      chk("empty in reset", empty_flag_n, 1'h0);
      chk("full in reset", full_flag_n, 1'h1);
      chk("half in reset", half_full_flag_n, 1'h1);
      chk("data in reset", read_data, 16'h0000);
      nrst = 1'h1;
   endtask

   initial begin
      void'($urandom(32'ha5dd1e3f));
      nrst = 1'h0;
      write_en_n = 1'h1;
      write_data = 16'h0000;
      oe_n = 1'h0;
      go = 1'h0;
      rate = 3'h4;
      reset_check();
      // Output drive follows the enable
      chk("drive on", read_data_oe_n, 1'h0);
      oe_n = 1'h1;
      #1;
      chk("drive off", read_data_oe_n, 1'h1);
      oe_n = 1'h0;
      // Fill with reads stopped; one extra write must be refused
      for (i = 1; i <= DEPTH + 1; i++) begin
         put(1'h1, 16'($urandom));
         @(posedge write_clock);
         #1;
         chk("half flag", half_full_flag_n, i <= DEPTH / 2);
         chk("full flag", full_flag_n, i < DEPTH);
      end
      chk("stored", exp.size(), DEPTH);
      chk("not empty", empty_flag_n, 1'h1);
      // Slow drain from full
      go = 1'h1;
      rate = 3'h2;
      drain();
      last = read_data;
      chk("full cleared", full_flag_n, 1'h1);
      chk("half cleared", half_full_flag_n, 1'h1);
      // Requests while empty are ignored and the output holds
      rate = 3'h4;
      repeat (6) @(posedge read_clock);
      #1;
      chk("empty", empty_flag_n, 1'h0);
      chk("held", read_data, last);
      // Concurrent random traffic, writes gated at random
      rate = 3'h3;
      repeat (600) put(1'($urandom), 16'($urandom));
      drain();
      // Mid-run reset discards the contents and restarts both pointers
      go = 1'h0;
      repeat (5) put(1'h1, 16'($urandom));
      reset_check();
      exp.delete();
      put(1'h1, 16'h5a3c);
      go = 1'h1;
      drain();
      // One clock on both ports, random traffic again
      @(negedge write_clock);
      tie = 1'h1;
      repeat (300) put(1'($urandom), 16'($urandom));
      drain();
      final_report();
   end

   // Watchdog: the sequence needs about 20 us
   initial begin
      #400000;
      fails++;
      final_report();
   end
endmodule // dcf_fifo_tb_top
